//--- hw/standby_params.svh
`ifndef STANDBY_PARAMS_SVH
`define STANDBY_PARAMS_SVH

// trap vector pair, high byte address first
`define TRAP_VEC_HI 16'hffee
`define TRAP_VEC_LO 16'hffef

// address error window bounds
`define TRAP_LOW_END_NARROW 16'h001f
`define TRAP_LOW_END_WIDE 16'h007f
`define TRAP_UPPER_START_M5 16'h0200
`define TRAP_UPPER_START_M7 16'h0100
`define TRAP_UPPER_END 16'hefff

// operating mode codes that change pin or trap behaviour
`define MODE_NONMUX_LOWADDR 3'h1
`define MODE_NONMUX_PORTADDR 3'h5
`define MODE_SINGLE_CHIP 3'h7
`define MODE_UPPER_ADDR_LAST 3'h4

// pin levels
`define PORT_ALL_ONES 8'hff
`define PORT2_ALL_ONES 5'h1f
`define PORT_ALL_ZERO 8'h00
`define PORT2_ALL_ZERO 5'h00

// mode loaded by power-on reset, before the strap pins are first sampled
`define MODE_RESET_VALUE 3'h7

`endif

//--- hw/standby_pkg.sv
package standby_pkg;
	// power sequencing states, one-hot
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_STANDBY = 4'b0100,
		ST_RESET = 4'b1000
	} pwr_state_t;

	typedef logic [2:0] op_mode_t;
endpackage

//--- hw/trap_range_check.sv
`timescale 1ns/1ps
`include "standby_params.svh"

module trap_range_check (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic fetch_valid_in,
	input wire logic [15:0] fetch_addr_in,
	input wire standby_pkg::op_mode_t mode_in,
	output logic hit_out
);
	import standby_pkg::*;

	logic hit_q;
	logic hit_d;
	logic wide_low;
	logic is_m5;
	logic is_m7;
	logic [15:0] low_end;
	logic [15:0] upper_start;
	logic in_low;
	logic in_upper;

	// per-mode window; everything outside it is resident or external space
	assign is_m5 = (mode_in == `MODE_NONMUX_PORTADDR);
	assign is_m7 = (mode_in == `MODE_SINGLE_CHIP);
	assign wide_low = is_m5 | is_m7;
	assign low_end = wide_low ? `TRAP_LOW_END_WIDE : `TRAP_LOW_END_NARROW;
	assign upper_start = is_m5 ? `TRAP_UPPER_START_M5 : `TRAP_UPPER_START_M7;
	assign in_low = (fetch_addr_in <= low_end);
	// external space is never flagged, even when nothing answers there
	assign in_upper = wide_low && (fetch_addr_in >= upper_start) && (fetch_addr_in <= `TRAP_UPPER_END);
	// only opcode fetches are checked, data cycles never reach here
	assign hit_d = fetch_valid_in & (in_low | in_upper);

	// latched on the fetch cycle itself
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			hit_q <= 1'b0;
		end else begin
			hit_q <= hit_d;
		end
	end

	assign hit_out = hit_q;

	a_fetch_only_trap: assert property (@(posedge clk_in) disable iff (srst_in)
		!fetch_valid_in |=> !hit_q)
		else $error("address trap raised without a fetch");
	a_external_no_trap: assert property (@(posedge clk_in) disable iff (srst_in)
		(fetch_valid_in && fetch_addr_in > `TRAP_UPPER_END) |=> !hit_q)
		else $error("address trap raised for external space");
endmodule

//--- hw/standby_trap_pin_ctrl.sv
`timescale 1ns/1ps
`include "standby_params.svh"

module standby_trap_pin_ctrl (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic low_power_request_n_in,
	input wire logic chip_init_pin_n_in,
	input wire standby_pkg::op_mode_t mode_strap_in,
	input wire logic address_strobe_pin_in,
	input wire logic bus_phase_e_in,
	input wire logic sleep_instruction_in,
	input wire logic instr_boundary_in,
	input wire logic fetch_valid_in,
	input wire logic [15:0] fetch_addr_in,
	input wire logic opcode_undefined_in,
	input wire logic other_irq_in,
	input wire logic [15:0] other_vector_in,
	input wire logic ram_write_req_in,
	input wire logic standby_flag_set_in,
	input wire logic standby_flag_clr_in,
	input wire logic [7:0] core_port1_val_in,
	input wire logic [7:0] core_port1_oe_in,
	input wire logic [4:0] core_port2_val_in,
	input wire logic [4:0] core_port2_oe_in,
	input wire logic [7:0] core_port3_val_in,
	input wire logic core_port3_oe_in,
	input wire logic [7:0] core_port4_val_in,
	input wire logic [7:0] core_port4_oe_in,
	input wire logic core_address_latch_strobe_in,
	input wire logic core_rw_val_in,
	input wire logic core_strobe_oe_in,
	output logic cpu_reset_out,
	output logic cpu_clock_enable_out,
	output logic periph_clock_enable_out,
	output logic ram_write_enable_out,
	output logic standby_flag_out,
	output logic trap_take_out,
	output logic other_irq_take_out,
	output logic [15:0] vector_addr_out,
	output logic reset_vector_fetch_out,
	output logic [3:0] state_out,
	output standby_pkg::op_mode_t mode_out,
	output logic [7:0] port1_out,
	output logic [7:0] port1_oe_out,
	output logic [4:0] port2_out,
	output logic [4:0] port2_oe_out,
	output logic [7:0] port3_out,
	output logic port3_oe_out,
	output logic [7:0] port4_out,
	output logic [7:0] port4_oe_out,
	output logic address_strobe_pin_out,
	output logic address_strobe_pin_oe_out,
	output logic read_write_strobe_pin_out,
	output logic read_write_strobe_pin_oe_out
);
	import standby_pkg::*;

	// pin synchronisers; first stages read only by second stages
	logic lpr_n_m_q, lpr_n_s_q;
	logic init_n_m_q, init_n_s_q;
	logic as_m_q, as_s_q;
	op_mode_t mode_m_q, mode_s_q;

	always_ff @(posedge clk_in) begin
		lpr_n_m_q <= low_power_request_n_in;
		lpr_n_s_q <= lpr_n_m_q;
		init_n_m_q <= chip_init_pin_n_in;
		init_n_s_q <= init_n_m_q;
		as_m_q <= address_strobe_pin_in;
		as_s_q <= as_m_q;
		mode_m_q <= mode_strap_in;
		mode_s_q <= mode_m_q;
	end

	pwr_state_t state_q, state_d;
	op_mode_t mode_q;
	logic in_active, in_sleep, in_standby, in_reset;
	logic wake_irq;
	logic trap_hit;
	logic trap_pend_q, trap_pend_set;
	logic trap_take_q, trap_take_d;
	logic other_take_q, other_take_d;
	logic flag_q;
	logic init_q;
	logic mux_mode, is_m1, is_m5, is_m7, upper_addr_mode;
	logic e_high;

	assign in_active = (state_q == ST_ACTIVE);
	assign in_sleep = (state_q == ST_SLEEP);
	assign in_standby = (state_q == ST_STANDBY);
	assign in_reset = (state_q == ST_RESET);
	assign wake_irq = other_irq_in | trap_pend_q;

	// standby beats reset, reset beats everything else
	always_comb begin
		state_d = state_q;
		if (!lpr_n_s_q) begin
			state_d = ST_STANDBY;
		end else if (!init_n_s_q) begin
			state_d = ST_RESET;
		end else begin
			case (state_q)
				ST_ACTIVE: state_d = sleep_instruction_in ? ST_SLEEP : ST_ACTIVE;
				ST_SLEEP: state_d = wake_irq ? ST_ACTIVE : ST_SLEEP;
				ST_STANDBY: state_d = ST_STANDBY;
				ST_RESET: state_d = ST_ACTIVE;
				default: state_d = ST_RESET;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_q <= ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// strap caught while reset is held, so it is stable afterwards
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mode_q <= `MODE_RESET_VALUE;
		end else if (in_reset) begin
			mode_q <= mode_s_q;
		end
	end

	// mode decode
	assign mux_mode = ~mode_q[0];
	assign is_m1 = (mode_q == `MODE_NONMUX_LOWADDR);
	assign is_m5 = (mode_q == `MODE_NONMUX_PORTADDR);
	assign is_m7 = (mode_q == `MODE_SINGLE_CHIP);
	assign upper_addr_mode = (mode_q <= `MODE_UPPER_ADDR_LAST);
	assign e_high = bus_phase_e_in;

	trap_range_check u_range (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.fetch_valid_in(fetch_valid_in & in_active),
		.fetch_addr_in(fetch_addr_in),
		.mode_in(mode_q),
		.hit_out(trap_hit)
	);

	// opcode and address errors share one pending trap; set wins over clear
	assign trap_pend_set = opcode_undefined_in | trap_hit;
	assign trap_take_d = in_active & instr_boundary_in & trap_pend_q & ~trap_take_q;
	// trap masks any other source at the same boundary
	assign other_take_d = in_active & instr_boundary_in & other_irq_in & ~trap_pend_q & ~other_take_q;

	always_ff @(posedge clk_in) begin
		if (srst_in || in_reset) begin
			trap_pend_q <= 1'b0;
			trap_take_q <= 1'b0;
			other_take_q <= 1'b0;
			vector_addr_out <= `TRAP_VEC_HI;
		end else begin
			trap_pend_q <= trap_pend_set | (trap_pend_q & ~trap_take_q);
			trap_take_q <= trap_take_d;
			other_take_q <= other_take_d;
			if (trap_take_d) begin
				vector_addr_out <= `TRAP_VEC_HI;
			end else if (other_take_d) begin
				vector_addr_out <= other_vector_in;
			end
		end
	end

	// flag only cleared by power-on reset or software; set wins
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= standby_flag_set_in | (flag_q & ~standby_flag_clr_in);
		end
	end

	// pulse marking the reset vector fetch after any reset start
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			init_q <= 1'b0;
		end else begin
			init_q <= in_reset & (state_d == ST_ACTIVE);
		end
	end

	// pin next values per state
	logic [7:0] p1_d, p1_oe_d, p3_d, p4_d, p4_oe_d;
	logic [4:0] p2_d, p2_oe_d;
	logic p3_oe_d, as_d, as_oe_d, rw_d, rw_oe_d;
	logic p3_reset_oe, p3_sleep_oe, as_reset_oe;

	// sleep, multiplexed modes: ones in low phase, float in high phase
	assign p3_sleep_oe = mux_mode & ~e_high;
	// reset, multiplexed modes: both phases driven, high phase floats when strobe pin is pulled low
	assign p3_reset_oe = mux_mode & ~(e_high & ~as_s_q);
	assign as_reset_oe = is_m5 | (~is_m7 & ~e_high);

	assign p1_d = in_active ? core_port1_val_in :
		(in_sleep && is_m1) ? `PORT_ALL_ONES : in_sleep ? port1_out : `PORT_ALL_ZERO;
	assign p1_oe_d = in_active ? core_port1_oe_in :
		(in_sleep && is_m1) ? `PORT_ALL_ONES : in_sleep ? port1_oe_out : `PORT_ALL_ZERO;
	assign p2_d = in_active ? core_port2_val_in : in_sleep ? port2_out : `PORT2_ALL_ZERO;
	assign p2_oe_d = in_active ? core_port2_oe_in : in_sleep ? port2_oe_out : `PORT2_ALL_ZERO;
	assign p3_d = in_active ? core_port3_val_in :
		(in_sleep && is_m7) ? port3_out : `PORT_ALL_ONES;
	assign p3_oe_d = in_active ? core_port3_oe_in :
		in_sleep ? (is_m7 ? port3_oe_out : p3_sleep_oe) :
		in_reset ? p3_reset_oe : 1'b0;
	assign p4_d = in_active ? core_port4_val_in :
		(in_sleep && upper_addr_mode) ? `PORT_ALL_ONES : in_sleep ? port4_out : `PORT_ALL_ZERO;
	assign p4_oe_d = in_active ? core_port4_oe_in :
		(in_sleep && upper_addr_mode) ? `PORT_ALL_ONES : in_sleep ? port4_oe_out : `PORT_ALL_ZERO;
	assign as_d = (in_active || (in_sleep && !is_m5)) ? core_address_latch_strobe_in : 1'b1;
	assign as_oe_d = in_active ? core_strobe_oe_in :
		in_sleep ? ~is_m7 : in_reset ? as_reset_oe : 1'b0;
	// strobe driven as a read cycle in sleep and reset, so memories never see a write; it floats in standby
	assign rw_d = in_active ? core_rw_val_in : 1'b1;
	assign rw_oe_d = in_active ? core_strobe_oe_in : (in_sleep | in_reset);

	// all pins float after power-on reset until the state machine takes over
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			port1_out <= `PORT_ALL_ZERO;
			port1_oe_out <= `PORT_ALL_ZERO;
			port2_out <= `PORT2_ALL_ZERO;
			port2_oe_out <= `PORT2_ALL_ZERO;
			port3_out <= `PORT_ALL_ONES;
			port3_oe_out <= 1'b0;
			port4_out <= `PORT_ALL_ZERO;
			port4_oe_out <= `PORT_ALL_ZERO;
			address_strobe_pin_out <= 1'b1;
			address_strobe_pin_oe_out <= 1'b0;
			read_write_strobe_pin_out <= 1'b1;
			read_write_strobe_pin_oe_out <= 1'b0;
		end else begin
			port1_out <= p1_d;
			port1_oe_out <= p1_oe_d;
			port2_out <= p2_d;
			port2_oe_out <= p2_oe_d;
			port3_out <= p3_d;
			port3_oe_out <= p3_oe_d;
			port4_out <= p4_d;
			port4_oe_out <= p4_oe_d;
			address_strobe_pin_out <= as_d;
			address_strobe_pin_oe_out <= as_oe_d;
			read_write_strobe_pin_out <= rw_d;
			read_write_strobe_pin_oe_out <= rw_oe_d;
		end
	end

	// clock, reset and ram control follow the next state
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cpu_reset_out <= 1'b1;
			cpu_clock_enable_out <= 1'b0;
			periph_clock_enable_out <= 1'b0;
			ram_write_enable_out <= 1'b0;
		end else begin
			cpu_reset_out <= (state_d == ST_RESET) | (state_d == ST_STANDBY);
			cpu_clock_enable_out <= (state_d == ST_ACTIVE) | (state_d == ST_RESET);
			periph_clock_enable_out <= (state_d != ST_STANDBY);
			ram_write_enable_out <= ram_write_req_in & in_active & (state_d == ST_ACTIVE);
		end
	end

	assign standby_flag_out = flag_q;
	assign trap_take_out = trap_take_q;
	assign other_irq_take_out = other_take_q;
	assign reset_vector_fetch_out = init_q;
	assign state_out = state_q;
	assign mode_out = mode_q;

	a_standby_stops_all: assert property (@(posedge clk_in) disable iff (srst_in)
		!lpr_n_s_q |=> (cpu_reset_out && !periph_clock_enable_out && !cpu_clock_enable_out))
		else $error("standby did not stop clocks");
	a_ram_frozen: assert property (@(posedge clk_in) disable iff (srst_in)
		in_standby |=> !ram_write_enable_out)
		else $error("ram written during standby");
	a_standby_exit_path: assert property (@(posedge clk_in) disable iff (srst_in)
		(in_standby && lpr_n_s_q && !init_n_s_q) |=> (in_reset && cpu_reset_out))
		else $error("standby not left through reset start");
	a_standby_no_irq_exit: assert property (@(posedge clk_in) disable iff (srst_in)
		in_standby |=> (in_standby || in_reset))
		else $error("standby left without reset start");
	a_flag_survives: assert property (@(posedge clk_in) disable iff (srst_in)
		(flag_q && !standby_flag_clr_in) |=> flag_q)
		else $error("standby flag lost");
	a_trap_vector: assert property (@(posedge clk_in) disable iff (srst_in)
		trap_take_q |-> (vector_addr_out == `TRAP_VEC_HI))
		else $error("trap took wrong vector");
	a_trap_first: assert property (@(posedge clk_in) disable iff (srst_in)
		trap_take_q |-> !other_take_q)
		else $error("other interrupt taken with trap");
	a_trap_handover: assert property (@(posedge clk_in) disable iff (srst_in)
		(opcode_undefined_in && in_active && lpr_n_s_q && init_n_s_q) ##1
		(in_active && instr_boundary_in && lpr_n_s_q && init_n_s_q) |=> trap_take_q)
		else $error("trap not handed over at boundary");
	a_sleep_rw_high: assert property (@(posedge clk_in) disable iff (srst_in)
		in_sleep |=> (read_write_strobe_pin_out && read_write_strobe_pin_oe_out))
		else $error("rw strobe not high in sleep");
	a_sleep_port3_phase: assert property (@(posedge clk_in) disable iff (srst_in)
		(in_sleep && state_d == ST_SLEEP && mux_mode) |=> (port3_oe_out == !$past(e_high)))
		else $error("port 3 phase drive wrong in sleep");
	a_sleep_hold_io: assert property (@(posedge clk_in) disable iff (srst_in)
		(in_sleep && state_d == ST_SLEEP && !is_m1) |=> $stable(port1_out) && $stable(port1_oe_out))
		else $error("port 1 changed in sleep");
	a_reset_port3_float: assert property (@(posedge clk_in) disable iff (srst_in)
		(in_reset && state_d == ST_RESET && e_high && !as_s_q) |=> !port3_oe_out)
		else $error("port 3 driven against pulled strobe");
	a_reset_port3_ones: assert property (@(posedge clk_in) disable iff (srst_in)
		(in_reset && state_d == ST_RESET && mux_mode && as_s_q) |=> (port3_oe_out && port3_out == `PORT_ALL_ONES))
		else $error("port 3 not ones in reset");

	c_enter_standby: cover property (@(posedge clk_in) in_active ##1 in_standby);
	c_standby_restart: cover property (@(posedge clk_in) in_standby ##1 in_reset ##[1:20] in_active);
	c_trap_taken: cover property (@(posedge clk_in) trap_take_q);
	c_sleep_wake: cover property (@(posedge clk_in) in_sleep ##1 in_active);
endmodule

//--- bench/ext_mem_model.sv
`timescale 1ns/1ps

module ext_mem_model (
	input wire logic clk_in,
	input wire logic chip_init_pin_n_in,
	input wire logic bus_phase_e_in,
	input wire logic rw_in,
	output logic mem_oe_out,
	output logic [7:0] mem_data_out
);
	logic [7:0] pat_q = 8'h5a;
	// memory reads only in the e-high phase, and stays off the bus while the reset pin is low
	assign mem_oe_out = chip_init_pin_n_in && bus_phase_e_in && rw_in;
	// a released line never shows a stale copy: inverse pattern that moves every cycle
	assign mem_data_out = mem_oe_out ? pat_q : ~pat_q;
	// pattern source
	always_ff @(posedge clk_in) begin
		pat_q <= pat_q + 8'h01;
	end
endmodule

//--- bench/tb.sv
`timescale 1ns/1ps

module tb;
	import standby_pkg::*;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic lp_n = 1'b1, init_n = 1'b1, strobe_sense = 1'b1, e_ph = 1'b0;
	logic sleep_go = 1'b0, bnd = 1'b0, fv = 1'b0, ud = 1'b0, irq = 1'b0;
	logic ram_req = 1'b0, fset = 1'b0, fclr = 1'b0;
	logic [15:0] faddr = 16'h0000;
	op_mode_t strap = 3'h7;
	op_mode_t md;
	logic [7:0] cv = 8'h3c;
	logic cpu_rst, cpu_ce, per_ce, ram_we, flag, trap_tk, irq_tk, rvf, p3_oe, rw_o, rw_oe, mem_oe;
	logic [15:0] vec;
	logic [3:0] st;
	logic [7:0] p1, p1_oe, p3, mem_d, p4, p4_oe;
	logic as_o, as_oe;
	logic [4:0] p2, p2_oe;
	int error_cnt = 0, checks = 0, cyc = 0;

	// core-side pin values all follow one pattern so sleep capture can be seen
	standby_trap_pin_ctrl u_dut (
		.clk_in(clk_in), .srst_in(srst_in),
		.low_power_request_n_in(lp_n), .chip_init_pin_n_in(init_n),
		.mode_strap_in(strap), .address_strobe_pin_in(strobe_sense),
		.bus_phase_e_in(e_ph), .sleep_instruction_in(sleep_go),
		.instr_boundary_in(bnd), .fetch_valid_in(fv), .fetch_addr_in(faddr),
		.opcode_undefined_in(ud), .other_irq_in(irq), .other_vector_in({cv, ~cv}),
		.ram_write_req_in(ram_req), .standby_flag_set_in(fset), .standby_flag_clr_in(fclr),
		.core_port1_val_in(cv), .core_port1_oe_in(~cv),
		.core_port2_val_in(cv[4:0]), .core_port2_oe_in(~cv[4:0]),
		.core_port3_val_in(cv), .core_port3_oe_in(cv[0]),
		.core_port4_val_in(cv), .core_port4_oe_in(~cv),
		.core_address_latch_strobe_in(cv[1]), .core_rw_val_in(cv[2]), .core_strobe_oe_in(cv[3]),
		.cpu_reset_out(cpu_rst), .cpu_clock_enable_out(cpu_ce), .periph_clock_enable_out(per_ce),
		.ram_write_enable_out(ram_we), .standby_flag_out(flag), .trap_take_out(trap_tk),
		.other_irq_take_out(irq_tk), .vector_addr_out(vec), .reset_vector_fetch_out(rvf),
		.state_out(st), .mode_out(md),
		.port1_out(p1), .port1_oe_out(p1_oe), .port2_out(p2), .port2_oe_out(p2_oe),
		.port3_out(p3), .port3_oe_out(p3_oe), .port4_out(p4), .port4_oe_out(p4_oe),
		.address_strobe_pin_out(as_o), .address_strobe_pin_oe_out(as_oe),
		.read_write_strobe_pin_out(rw_o), .read_write_strobe_pin_oe_out(rw_oe)
	);

	ext_mem_model u_mem (
		.clk_in(clk_in), .chip_init_pin_n_in(init_n), .bus_phase_e_in(e_ph),
		.rw_in(rw_o), .mem_oe_out(mem_oe), .mem_data_out(mem_d)
	);

	// 250 MHz clock
	initial begin
		forever #2 clk_in = ~clk_in;
	end

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic cyc_n(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic close_out;
		if (error_cnt == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// mode strap is only taken while the device is in its reset state, which the reset pin holds it in
	task automatic init_mode(input op_mode_t m);
		int k;
		strap = m;
		init_n = 1'b0;
		cyc_n(6);
		init_n = 1'b1;
		k = 0;
		while (rvf !== 1'b1 && k < 8) begin
			cyc_n(1);
			k++;
		end
		check("reset vector fetch", {15'h0, rvf}, 16'h0001);
		check("state active", {12'h0, st}, 16'h0001);
		check("mode", {13'h0, md}, {13'h0, m});
	endtask

	// trap is requested, boundary follows two cycles later, pulses are counted
	task automatic trap_probe(input logic u, input logic f, input logic [15:0] a, input logic exp);
		int hits;
		ud = u;
		fv = f;
		faddr = a;
		cyc_n(1);
		ud = 1'b0;
		fv = 1'b0;
		cyc_n(1);
		bnd = 1'b1;
		cyc_n(1);
		bnd = 1'b0;
		hits = 0;
		repeat (4) begin
			if (trap_tk === 1'b1) begin
				hits++;
				check("trap vector", vec, 16'hffee);
				check("lower irq held off", {15'h0, irq_tk}, 16'h0000);
			end
			cyc_n(1);
		end
		check("trap count", 16'(hits), {15'h0, exp});
	endtask

	function automatic logic exp_trap(input op_mode_t m, input logic [15:0] a);
		if (m == 3'h5) return a <= 16'h007f || (a >= 16'h0200 && a <= 16'hefff);
		if (m == 3'h7) return a <= 16'h007f || (a >= 16'h0100 && a <= 16'hefff);
		return a <= 16'h001f;
	endfunction

	task automatic sc_reset_pins;
		strap = 3'h4;
		init_n = 1'b0;
		cyc_n(5);
		check("p3 ones e low", {7'h0, p3_oe, p3}, 16'h01ff);
		check("rw read in reset", {14'h0, rw_o, rw_oe}, 16'h0003);
		check("p4 float in reset", {8'h0, p4_oe}, 16'h0000);
		check("strobe e low reset", {14'h0, as_o, as_oe}, 16'h0003);
		e_ph = 1'b1;
		cyc_n(2);
		check("strobe e high reset", {15'h0, as_oe}, 16'h0000);
		check("p3 ones e high", {7'h0, p3_oe, p3}, 16'h01ff);
		check("no contention", {15'h0, p3_oe & mem_oe}, 16'h0000);
		strobe_sense = 1'b0;
		cyc_n(4);
		check("p3 float pulled", {15'h0, p3_oe}, 16'h0000);
		strobe_sense = 1'b1;
		e_ph = 1'b0;
		init_mode(3'h4);
	endtask

	task automatic sc_sleep;
		int k;
		cv = 8'h15;
		cyc_n(2);
		sleep_go = 1'b1;
		cyc_n(1);
		sleep_go = 1'b0;
		cv = 8'h6a;
		cyc_n(2);
		check("sleep state", {12'h0, st}, 16'h0002);
		check("clocks in sleep", {14'h0, cpu_ce, per_ce}, 16'h0001);
		check("rw read", {14'h0, rw_o, rw_oe}, 16'h0003);
		check("p3 ones e low", {7'h0, p3_oe, p3}, 16'h01ff);
		check("p1 hold", {p1_oe, p1}, 16'hea15);
		check("p2 hold", {3'h0, p2_oe, 3'h0, p2}, 16'h0a15);
		check("p4 address ones", {p4_oe, p4}, 16'hffff);
		check("strobe driven sleep", {15'h0, as_oe}, 16'h0001);
		e_ph = 1'b1;
		cyc_n(2);
		check("p3 float e high", {15'h0, p3_oe}, 16'h0000);
		e_ph = 1'b0;
		irq = 1'b1;
		k = 0;
		while (st !== 4'h1 && k < 6) begin
			cyc_n(1);
			k++;
		end
		check("irq ends sleep", {12'h0, st}, 16'h0001);
		irq = 1'b0;
		cv = 8'h3c;
		cyc_n(3);
		// lower source taken at a boundary when no trap is pending
		irq = 1'b1;
		bnd = 1'b1;
		cyc_n(1);
		bnd = 1'b0;
		irq = 1'b0;
		check("lower irq taken", {15'h0, irq_tk}, 16'h0001);
		check("lower irq vector", vec, 16'h3cc3);
		cyc_n(2);
	endtask

	task automatic sc_standby;
		fset = 1'b1;
		cyc_n(1);
		fset = 1'b0;
		ram_req = 1'b1;
		lp_n = 1'b0;
		cyc_n(5);
		check("standby state", {12'h0, st}, 16'h0004);
		check("held and stopped", {13'h0, cpu_rst, cpu_ce, per_ce}, 16'h0004);
		check("ram write blocked", {15'h0, ram_we}, 16'h0000);
		irq = 1'b1;
		cyc_n(5);
		check("irq no exit", {12'h0, st}, 16'h0004);
		irq = 1'b0;
		ram_req = 1'b0;
		init_n = 1'b0;
		cyc_n(2);
		lp_n = 1'b1;
		init_mode(3'h4);
		check("flag kept", {15'h0, flag}, 16'h0001);
	endtask

	task automatic sc_addr_trap;
		logic [15:0] probe [10] = '{16'h001f, 16'h0020, 16'h007f, 16'h0080, 16'h00ff,
			16'h0100, 16'h01ff, 16'h0200, 16'hefff, 16'hf000};
		op_mode_t modes [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
		foreach (modes[i]) begin
			init_mode(modes[i]);
			foreach (probe[j]) begin
				trap_probe(1'b0, 1'b1, probe[j], exp_trap(modes[i], probe[j]));
			end
			trap_probe(1'b0, 1'b0, 16'h0000, 1'b0);
		end
	endtask

	// main sequence
	initial begin
		cyc_n(2);
		srst_in = 1'b0;
		init_mode(3'h4);
		sc_reset_pins;
		sc_sleep;
		irq = 1'b1;
		trap_probe(1'b1, 1'b0, 16'h0000, 1'b1);
		irq = 1'b0;
		cyc_n(3);
		sc_standby;
		sc_addr_trap;
		close_out;
	end

	// hang guard
	always @(posedge clk_in) begin
		cyc++;
		if (cyc > 20000) begin
			error_cnt++;
			close_out;
		end
	end
endmodule
